// ### core/dpb_defines.svh
`ifndef DPB_DEFINES_SVH
`define DPB_DEFINES_SVH
`define DPB_DATA_W 18
`define DPB_LANES 2
`define DPB_LANE_W 9
`define DPB_ADDR_W 18
`define DPB_BURST 4
`define DPB_ARR_IDX_W 4
`define DPB_CAL_CYCLES 11'h400
`define DPB_CAL_CNT_W 10
`define DPB_IMP_W 7
`define DPB_IMP_DEFAULT_OHMS 7'h32
`define DPB_IMP_MAX 7'h7F
`endif

// ### core/dpb_pkg.sv
`include "dpb_defines.svh"
package dpb_pkg;
    typedef logic [`DPB_DATA_W-1:0] dpb_word_t;
    typedef logic [`DPB_LANES-1:0] dpb_mask_t;
    typedef logic [`DPB_ADDR_W-1:0] dpb_addr_t;
    typedef logic [`DPB_IMP_W-1:0] dpb_imp_t;
    typedef enum logic [1:0] {
        DPB_CAL_INIT = 2'b01,
        DPB_CAL_TRACK = 2'b10
    } dpb_cal_t;
endpackage : dpb_pkg

// ### core/dpb_burst_sram.sv
`timescale 1ns/1ps
`include "dpb_defines.svh"
module dpb_burst_sram (
    // System clock domain.
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clockEnable,
    // Input and output clock pins.
    input wire logic kClk,
    input wire logic cClk,
    input wire logic cClkN,
    // Requests and shared address.
    input wire logic rdSelN,
    input wire logic wrSelN,
    input wire dpb_pkg::dpb_addr_t addrIn,
    // Write data port.
    input wire dpb_pkg::dpb_word_t wrData,
    input wire dpb_pkg::dpb_mask_t byte_write_mask_n,
    // Read data port.
    output logic [`DPB_DATA_W-1:0] rdData,
    output logic rdDataOe,
    // Echo clocks.
    output logic echo_clock_true,
    output logic echo_clock_comp,
    // Impedance control and status.
    input wire logic impedance_set_ball,
    output logic [`DPB_IMP_W-1:0] impCode,
    output logic impReady,
    output logic singleClkMode
);
    localparam int IDXW = `DPB_ARR_IDX_W;
    localparam int MEMW = IDXW + 2;

    function automatic dpb_pkg::dpb_word_t overlay(input dpb_pkg::dpb_word_t base,
            input dpb_pkg::dpb_word_t nw, input dpb_pkg::dpb_mask_t maskN, input logic hit);
        dpb_pkg::dpb_word_t r;
        r = base;
        for (int b = 0; b < `DPB_LANES; b++) begin
            if (hit && !maskN[b]) begin
                r[b*`DPB_LANE_W +: `DPB_LANE_W] = nw[b*`DPB_LANE_W +: `DPB_LANE_W];
            end
        end
        return r;
    endfunction : overlay

    // Reset and enable cross into the link domain as levels.
    logic kRstMeta_ff, kRst_ff, kCeMeta_ff, kCe_ff, cHiMeta_ff, cHi_ff;
    always_ff @(posedge kClk) begin
        kRstMeta_ff <= sys_rst;
        kRst_ff <= kRstMeta_ff;
        kCeMeta_ff <= clockEnable;
        kCe_ff <= kCeMeta_ff;
        cHiMeta_ff <= cClk & cClkN;
        cHi_ff <= cHiMeta_ff;
    end
    // Output registers stay on the input clock pair: the output clocks are assumed phase aligned
    // with it, which saves a third clock domain at the cost of no flight-time compensation.
    assign singleClkMode = cHi_ff;

    // Request decode: each port keeps its own busy flag.
    logic rdBusy_ff, rdFetch_ff, rdHalf_ff, wrBusy_ff, wrS2_ff, wrS3_ff;
    wire rdAccept = !rdSelN && !rdBusy_ff;
    wire wrAccept = !wrSelN && !wrBusy_ff;

    always_ff @(posedge kClk) begin
        if (kRst_ff) begin
            rdBusy_ff <= 1'b0;
            rdFetch_ff <= 1'b0;
            wrBusy_ff <= 1'b0;
            wrS2_ff <= 1'b0;
            wrS3_ff <= 1'b0;
        end else if (kCe_ff) begin
            rdBusy_ff <= rdAccept;
            rdFetch_ff <= rdBusy_ff;
            wrBusy_ff <= wrAccept;
            wrS2_ff <= wrBusy_ff;
            wrS3_ff <= wrS2_ff;
        end
    end

    // Write capture: even words on the rising edge, odd words on the complementary edge.
    dpb_pkg::dpb_word_t negD_ff;
    dpb_pkg::dpb_mask_t negM_ff;
    always_ff @(negedge kClk) begin
        if (kCe_ff) begin
            negD_ff <= wrData;
            negM_ff <= byte_write_mask_n;
        end
    end

    dpb_pkg::dpb_addr_t wAddr_ff, wregAddr_ff, rdAddr_ff;
    dpb_pkg::dpb_word_t wBuf_ff [0:2];
    dpb_pkg::dpb_mask_t wMsk_ff [0:2];
    dpb_pkg::dpb_word_t wregData_ff [0:3];
    dpb_pkg::dpb_mask_t wregMsk_ff [0:3];
    logic wregValid_ff;

    always_ff @(posedge kClk) begin
        if (kCe_ff && wrBusy_ff) begin
            wAddr_ff <= addrIn;
            wBuf_ff[0] <= wrData;
            wMsk_ff[0] <= byte_write_mask_n;
        end
        if (kCe_ff && wrS2_ff) begin
            wBuf_ff[1] <= negD_ff;
            wMsk_ff[1] <= negM_ff;
            wBuf_ff[2] <= wrData;
            wMsk_ff[2] <= byte_write_mask_n;
        end
        if (kCe_ff && wrS3_ff) begin
            wregAddr_ff <= wAddr_ff;
            wregData_ff <= '{wBuf_ff[0], wBuf_ff[1], wBuf_ff[2], negD_ff};
            wregMsk_ff <= '{wMsk_ff[0], wMsk_ff[1], wMsk_ff[2], negM_ff};
        end
        if (kCe_ff && rdAccept) begin
            rdAddr_ff <= addrIn;
        end
    end

    always_ff @(posedge kClk) begin
        if (kRst_ff) begin
            wregValid_ff <= 1'b0;
        end else if (kCe_ff && wrS3_ff) begin
            wregValid_ff <= 1'b1;
        end
    end

    // Array: the previous burst leaves the write register only when the next one replaces it,
    // so the array may hold stale data for a while and every read must look at the register.
    dpb_pkg::dpb_word_t memArr [0:(1<<MEMW)-1];
    always_ff @(posedge kClk) begin
        if (kCe_ff && wrS3_ff && wregValid_ff) begin
            for (int j = 0; j < `DPB_BURST; j++) begin
                memArr[{wregAddr_ff[IDXW-1:0], j[1:0]}] <=
                    overlay(memArr[{wregAddr_ff[IDXW-1:0], j[1:0]}], wregData_ff[j], wregMsk_ff[j], 1'b1);
            end
        end
    end

    // Coherent view of the addressed burst.
    wire wregHit = wregValid_ff && (wregAddr_ff == rdAddr_ff);
    dpb_pkg::dpb_word_t view [0:3];
    for (genvar j = 0; j < `DPB_BURST; j++) begin : g_view
        wire [MEMW-1:0] rdIdx = {rdAddr_ff[IDXW-1:0], 2'(j)};
        assign view[j] = overlay(memArr[rdIdx], wregData_ff[j], wregMsk_ff[j], wregHit);
    end

    // Read launch: word 0 and 2 on rising edges, 1 and 3 on complementary edges.
    dpb_pkg::dpb_word_t rdBuf_ff [1:3];
    dpb_pkg::dpb_word_t posQ_ff, negQ_ff;
    logic posOe_ff, negOe_ff;
    always_ff @(posedge kClk) begin
        if (kCe_ff && rdFetch_ff) begin
            posQ_ff <= view[0];
            rdBuf_ff <= '{view[1], view[2], view[3]};
        end else if (kCe_ff && rdHalf_ff) begin
            posQ_ff <= rdBuf_ff[2];
        end
    end

    always_ff @(posedge kClk) begin
        if (kRst_ff) begin
            posOe_ff <= 1'b0;
            rdHalf_ff <= 1'b0;
        end else if (kCe_ff) begin
            posOe_ff <= rdFetch_ff || rdHalf_ff;
            rdHalf_ff <= rdFetch_ff;
        end
    end

    always_ff @(negedge kClk) begin
        if (kRst_ff) begin
            negOe_ff <= 1'b0;
        end else if (kCe_ff) begin
            negOe_ff <= posOe_ff;
            negQ_ff <= rdHalf_ff ? rdBuf_ff[1] : rdBuf_ff[3];
        end
    end

    // Double-rate output: each half period shows the register of its own edge.
    assign rdData = kClk ? posQ_ff : negQ_ff;
    assign rdDataOe = kClk ? posOe_ff : negOe_ff;
    // No loop lock: echoes follow the input clock directly, so they stop and restart with it.
    assign echo_clock_true = kClk;
    assign echo_clock_comp = ~kClk;

    // Impedance tracking runs on the system clock, apart from the data path.
    logic zqMeta_ff, zqSync_ff;
    dpb_pkg::dpb_cal_t calState_ff;
    logic [`DPB_CAL_CNT_W-1:0] calCnt_ff;
    dpb_pkg::dpb_imp_t impCode_ff;
    localparam logic [`DPB_CAL_CNT_W-1:0] CAL_LAST = `DPB_CAL_CNT_W'(`DPB_CAL_CYCLES - 11'h001);
    wire calLast = (calCnt_ff == CAL_LAST);
    wire calStep = (calState_ff == dpb_pkg::DPB_CAL_INIT) || calLast;
    wire [`DPB_CAL_CNT_W-1:0] nxt_calCnt = calCnt_ff + `DPB_CAL_CNT_W'h001;
    wire codeDown = zqSync_ff && (impCode_ff != `DPB_IMP_W'h00);
    wire codeUp = !zqSync_ff && (impCode_ff != `DPB_IMP_MAX);
    dpb_pkg::dpb_imp_t nxt_impCode;
    assign nxt_impCode = codeDown ? impCode_ff - `DPB_IMP_W'h01 : codeUp ? impCode_ff + `DPB_IMP_W'h01 : impCode_ff;

    always_ff @(posedge clock) begin
        zqMeta_ff <= impedance_set_ball;
        zqSync_ff <= zqMeta_ff;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            calState_ff <= dpb_pkg::DPB_CAL_INIT;
            calCnt_ff <= '0;
            impCode_ff <= `DPB_IMP_DEFAULT_OHMS;
        end else if (clockEnable) begin
            calCnt_ff <= nxt_calCnt;
            if (calStep) begin
                impCode_ff <= nxt_impCode;
            end
            if (calLast) begin
                calState_ff <= dpb_pkg::DPB_CAL_TRACK;
            end
        end
    end
    assign impCode = impCode_ff;
    assign impReady = (calState_ff == dpb_pkg::DPB_CAL_TRACK);

    a_rd_spacing: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && rdAccept) |=> !rdAccept) else $error("read accepted on the in-between edge");
    a_wr_spacing: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && wrAccept) |=> !wrAccept) else $error("write accepted on the in-between edge");
    a_rd_latency: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && rdAccept) ##1 kCe_ff ##1 kCe_ff |=> posOe_ff) else $error("read data late");
    a_rd_burst_len: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && rdFetch_ff) ##1 kCe_ff |=> posOe_ff && !rdHalf_ff) else $error("read burst length wrong");
    a_rd_idle_float: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && !rdFetch_ff && !rdHalf_ff) |=> !posOe_ff) else $error("read port driven while idle");
    a_ports_indep: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && !rdSelN && !rdBusy_ff && !wrBusy_ff) |=> rdBusy_ff && (wrBusy_ff == !$past(wrSelN)))
        else $error("ports interfered");
    a_wr_addr_next: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && wrBusy_ff) |=> wAddr_ff == $past(addrIn)) else $error("write address not taken");
    a_wr_commit: assert property (@(posedge kClk) disable iff (kRst_ff)
        (kCe_ff && wrS3_ff) |=> wregValid_ff && wregAddr_ff == $past(wAddr_ff) && wregData_ff[3] == $past(negD_ff))
        else $error("write register not loaded");
    a_rd_oe_pair: assert property (@(negedge kClk) disable iff (kRst_ff)
        kCe_ff |=> negOe_ff == $past(posOe_ff)) else $error("odd word enable mismatch");
    a_cal_wait: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(impReady) |-> $past(calCnt_ff) == CAL_LAST) else $error("calibration ended early");
    a_cal_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        (impReady && !calLast) |=> $stable(impCode_ff)) else $error("impedance changed off schedule");
    c_rd_back: cover property (@(posedge kClk) disable iff (kRst_ff) rdAccept ##2 rdAccept);
    c_wr_then_rd: cover property (@(posedge kClk) disable iff (kRst_ff) rdFetch_ff && wregHit);
    c_concurrent: cover property (@(posedge kClk) disable iff (kRst_ff) rdAccept && wrAccept);
    c_cal_done: cover property (@(posedge clock) disable iff (sys_rst) $rose(impReady));
endmodule : dpb_burst_sram

// ### dv/dpb_ctrl_model.sv
`timescale 1ns/1ps
module dpb_ctrl_model (
    // Link clock.
    input wire logic kClk,
    // Requests, address and write data.
    output logic rdSelN,
    output logic wrSelN,
    output dpb_pkg::dpb_addr_t addrIn,
    output dpb_pkg::dpb_word_t wrData,
    output dpb_pkg::dpb_mask_t byte_write_mask_n,
    // Output clock pins.
    output logic cClk,
    output logic cClkN,
    // Returned read data.
    input wire dpb_pkg::dpb_word_t rdData,
    input wire logic rdDataOe
);
    dpb_pkg::dpb_word_t got [4];
    logic gotOe [4];
    logic oeAfter;
    // The link clock runs all the time, so it has settled before the first command.
    initial begin
        rdSelN = 1'b1;
        wrSelN = 1'b1;
        addrIn = 18'h00000;
        wrData = 18'h00000;
        byte_write_mask_n = 2'h3;
        cClk = 1'b1;
        cClkN = 1'b1;
    end
    task automatic writeBurst(input dpb_pkg::dpb_addr_t a, input logic [71:0] w, input logic [7:0] m,
        input logic holdSel);
        @(posedge kClk);
        #1 wrSelN = 1'b0;
        @(posedge kClk);
        #1 wrSelN = !holdSel;
        addrIn = a;
        for (int j = 0; j < 4; j++) begin
            wrData = w[j*18 +: 18];
            byte_write_mask_n = m[j*2 +: 2];
            if (j[0]) @(negedge kClk); else @(posedge kClk);
            #1 wrSelN = 1'b1;
        end
        // Released lines show the inverse so a stale value can never pass for data.
        wrData = ~wrData;
        byte_write_mask_n = ~byte_write_mask_n;
        addrIn = ~a;
    endtask : writeBurst
    task automatic readBurst(input dpb_pkg::dpb_addr_t a, input logic holdSel);
        @(posedge kClk);
        #1 rdSelN = 1'b0;
        addrIn = a;
        @(posedge kClk);
        #1 rdSelN = !holdSel;
        addrIn = ~a;
        @(posedge kClk);
        #1 rdSelN = 1'b1;
        for (int j = 0; j < 4; j++) begin
            if (j[0]) @(negedge kClk); else @(posedge kClk);
            #1 got[j] = rdData;
            gotOe[j] = rdDataOe;
        end
        @(posedge kClk);
        #1 oeAfter = rdDataOe;
    endtask : readBurst
endmodule : dpb_ctrl_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic kClk = 1'b0;
    logic sysRst = 1'b1;
    logic clockEnable = 1'b1;
    logic impBall = 1'b0;
    logic rdSelN, wrSelN, cClk, cClkN, rdDataOe, echoTrue, echoComp, impReady, singleClkMode;
    dpb_pkg::dpb_addr_t addrIn;
    dpb_pkg::dpb_word_t wrData;
    dpb_pkg::dpb_word_t rdData;
    dpb_pkg::dpb_mask_t byte_write_mask_n;
    logic [6:0] impCode;
    logic [71:0] exp5, nw;
    int nFail = 0;
    int compares = 0;
    int cycles = 0;
    int relCycles = 0;
    always #2 clock = ~clock;
    initial begin
        #7;
        forever #24 kClk = ~kClk;
    end
    dpb_burst_sram DUT (.clock(clock), .sys_rst(sysRst), .clockEnable(clockEnable), .kClk(kClk),
        .cClk(cClk), .cClkN(cClkN), .rdSelN(rdSelN), .wrSelN(wrSelN), .addrIn(addrIn), .wrData(wrData),
        .byte_write_mask_n(byte_write_mask_n), .rdData(rdData), .rdDataOe(rdDataOe),
        .echo_clock_true(echoTrue), .echo_clock_comp(echoComp), .impedance_set_ball(impBall),
        .impCode(impCode), .impReady(impReady), .singleClkMode(singleClkMode));
    dpb_ctrl_model ctrl (.kClk(kClk), .rdSelN(rdSelN), .wrSelN(wrSelN), .addrIn(addrIn), .wrData(wrData),
        .byte_write_mask_n(byte_write_mask_n), .cClk(cClk), .cClkN(cClkN), .rdData(rdData),
        .rdDataOe(rdDataOe));
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (!sysRst) relCycles <= relCycles + 1;
        if (cycles == 6000) begin
            nFail++;
            $display("Error at %0t: timeout %h %h", $time, cycles, 6000);
            summarize();
        end
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] n, input logic [7:0] m);
        merge = o;
        for (int j = 0; j < 8; j++)
            if (!m[j]) merge[j*9 +: 9] = n[j*9 +: 9];
    endfunction : merge
    task automatic checkBurst(input logic [71:0] w);
        for (int j = 0; j < 4; j++) begin
            chk(ctrl.got[j], w[j*18 +: 18]);
            chk({17'h0, ctrl.gotOe[j]}, 18'h00001);
        end
        chk({17'h0, ctrl.oeAfter}, 18'h00000);
    endtask : checkBurst
    task automatic tIdle();
        @(posedge kClk);
        #2 chk({16'h0, echoTrue, echoComp}, 18'h00002);
        chk({16'h0, rdDataOe, singleClkMode}, 18'h00001);
        @(negedge kClk);
        #2 chk({16'h0, echoTrue, echoComp}, 18'h00001);
        $display("test idle done");
    endtask : tIdle
    task automatic tBasic();
        exp5 = {18'h3C0F3, 18'h2A5A5, 18'h15A5A, 18'h0F0F0};
        ctrl.writeBurst(18'h00005, exp5, 8'h00, 1'b0);
        ctrl.readBurst(18'h00005, 1'b0);
        checkBurst(exp5);
        $display("test basic done");
    endtask : tBasic
    task automatic tMask();
        nw = {18'h12345, 18'h23456, 18'h34567, 18'h05678};
        ctrl.writeBurst(18'h00005, nw, 8'h36, 1'b0);
        exp5 = merge(exp5, nw, 8'h36);
        ctrl.readBurst(18'h00005, 1'b0);
        checkBurst(exp5);
        $display("test mask done");
    endtask : tMask
    task automatic tCoherent();
        nw = {18'h11111, 18'h22222, 18'h33333, 18'h04444};
        fork
            ctrl.writeBurst(18'h00005, nw, 8'h00, 1'b0);
            begin
                repeat (2) @(posedge kClk);
                ctrl.readBurst(18'h00005, 1'b0);
            end
        join
        exp5 = nw;
        checkBurst(exp5);
        $display("test coherent done");
    endtask : tCoherent
    task automatic tRefuse();
        nw = {18'h0ABCD, 18'h1BCDE, 18'h2CDEF, 18'h3DEF0};
        ctrl.writeBurst(18'h00009, nw, 8'h00, 1'b1);
        ctrl.readBurst(18'h00005, 1'b1);
        checkBurst(exp5);
        ctrl.readBurst(18'h00009, 1'b0);
        checkBurst(nw);
        $display("test refuse done");
    endtask : tRefuse
    task automatic tImp();
        while (impReady !== 1'b1 && relCycles < 1500) @(negedge clock);
        chk({17'h0, relCycles >= 1024 && relCycles <= 1040}, 18'h00001);
        chk({11'h0, impCode}, 18'h0007F);
        $display("test impedance done");
    endtask : tImp
    // A low enable must freeze the link side, so a request made then is lost.
    task automatic tFreeze();
        @(negedge clock) clockEnable = 1'b0;
        repeat (4) @(posedge kClk);
        ctrl.readBurst(18'h00005, 1'b0);
        chk({17'h0, ctrl.gotOe[0]}, 18'h00000);
        @(negedge clock) clockEnable = 1'b1;
        repeat (4) @(posedge kClk);
        ctrl.readBurst(18'h00005, 1'b0);
        checkBurst(exp5);
        $display("test freeze done");
    endtask : tFreeze
    initial begin
        repeat (48) @(negedge clock);
        chk({11'h0, impCode, impReady}, 18'h00064);
        sysRst = 1'b0;
        repeat (6) @(posedge kClk);
        tIdle();
        tBasic();
        tMask();
        tCoherent();
        tRefuse();
        tImp();
        tFreeze();
        summarize();
    end
endmodule : testbench
